// [odbu_core.sv]
// Debug unit: run control, breakpoints, trace, cycle-steal access, event pin.
`timescale 1ns/1ps
module odbu_core import odbu_pkg::*; (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic link_tck,
    input wire logic link_frame,
    input wire logic link_tdi,
    output logic link_tdo,
    input wire logic [15:0] core_pc,
    input wire logic core_insn_boundary,
    input wire odbu_mon_s mon,
    output logic core_halt,
    output logic core_stall,
    output logic core_reset,
    output logic periph_clk_run,
    output odbu_acc_s dbg_acc,
    input wire logic dbg_gnt,
    input wire logic [7:0] dbg_rdata,
    input wire logic evt_in,
    output logic evt_out,
    output logic evt_oe
);

    // Space and direction qualification shared by every slot.
    function automatic logic bp_qual(input odbu_bp_s b, input odbu_mon_s m);
        logic sp_ok;
        logic dir_ok;
        sp_ok = |(b.space_mask & (5'h01 << m.space));
        dir_ok = m.write ? b.wr : b.rd;
        return b.en && m.valid && sp_ok && dir_ok;
    endfunction : bp_qual

    odbu_cmd_s cmd_hold;
    logic req_tgl;
    logic rq_s1_q, rq_s2_q, rq_s3_q;
    logic evt_s1_q, evt_s2_q, evt_s3_q;
    odbu_state_e st_q, st_d;
    odbu_cmd_s cmd_q, cmd_d;
    odbu_acc_s acc_q, acc_d;
    logic [7:0] rdata_q, rdata_d;
    odbu_rsp_s rsp_q, rsp_d;
    logic ack_q, ack_d;
    odbu_bp_s bp_q [NUM_BP];
    odbu_bp_s bp_d [NUM_BP];
    logic [15:0] hi_q, hi_d;
    logic rout_q, rout_d;
    logic [7:0] cfg_q, cfg_d;
    logic halted_q, halted_d;
    logic halt_pend_q, halt_pend_d;
    logic step_q, step_d;
    logic [3:0] rst_q, rst_d;
    logic trace_vld_q, trace_vld_d;
    logic [15:0] trace_pc_q, trace_pc_d;
    logic [5:0] hit_q, hit_d;
    logic evto_q, evto_d;
    logic [NUM_BP-1:0] raw, eff, act_halt, act_evt;
    logic req_new, is_exec, evt_dir, trace_en, evt_fall, in_rng;
    logic partner, brk_halt, brk_evt;
    logic [1:0] comb, sel;

    // Serial link end on its own clock.
    odbu_link u_link (
        .link_tck(link_tck),
        .resetn(resetn),
        .link_frame(link_frame),
        .link_tdi(link_tdi),
        .link_tdo(link_tdo),
        .cmd_hold(cmd_hold),
        .req_tgl(req_tgl),
        .ack_tgl(ack_q),
        .rsp_word(rsp_q)
    );

    // Synchronisers for the request toggle and the event pin.
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rq_s1_q <= 1'b0;
            rq_s2_q <= 1'b0;
            rq_s3_q <= 1'b0;
            evt_s1_q <= 1'b1;
            evt_s2_q <= 1'b1;
            evt_s3_q <= 1'b1;
        end else begin
            rq_s1_q <= req_tgl;
            rq_s2_q <= rq_s1_q;
            rq_s3_q <= rq_s2_q;
            evt_s1_q <= evt_in;
            evt_s2_q <= evt_s1_q;
            evt_s3_q <= evt_s2_q;
        end
    end

    assign req_new = rq_s2_q ^ rq_s3_q;
    assign is_exec = (st_q == ST_EXEC);
    assign evt_dir = cfg_q[CF_EVT_OUT];
    assign trace_en = cfg_q[CF_TRACE];
    assign comb = cfg_q[CF_COMB_LSB +: 2];
    assign sel = cfg_q[CF_SEL_LSB +: 2];

    // Address comparators and per-slot actions.
    genvar g;
    generate
        for (g = 0; g < NUM_BP; g++) begin : g_act
            assign act_halt[g] = bp_q[g].halt;
            assign act_evt[g] = bp_q[g].evt;
        end
        for (g = 0; g < NUM_MATCH; g++) begin : g_match
            assign raw[g] = bp_qual(bp_q[g], mon) && (mon.addr == bp_q[g].addr);
        end
    endgenerate

    // Data-capable slot and range slot.
    assign raw[BP_DATA] = bp_qual(bp_q[BP_DATA], mon) && (mon.addr == bp_q[BP_DATA].addr)
        && (!bp_q[BP_DATA].dmatch || mon.data == bp_q[BP_DATA].data);
    assign in_rng = (mon.addr >= bp_q[BP_RANGE].addr) && (mon.addr <= hi_q);
    assign raw[BP_RANGE] = bp_qual(bp_q[BP_RANGE], mon) && (in_rng ^ rout_q);
    assign partner = (sel < 2'(NUM_MATCH)) ? raw[sel] : 1'b0;

    // A combined partner no longer fires alone; the pair fires as the data slot.
    always_comb begin
        eff = raw;
        if ((comb == CB_AND || comb == CB_OR) && sel < 2'(NUM_MATCH)) begin
            eff[sel] = 1'b0;
            eff[BP_DATA] = (comb == CB_AND) ? (raw[BP_DATA] & partner)
                                            : (raw[BP_DATA] | partner);
        end
    end

    // Break actions; an external falling edge requests a halt only while the event pin is an input.
    assign evt_fall = !evt_dir && evt_s3_q && !evt_s2_q;
    assign brk_halt = |(eff & act_halt) || evt_fall;
    assign brk_evt = |(eff & act_evt);

    // Command handling: decode, cycle-steal access and response.
    always_comb begin
        st_d = st_q;
        cmd_d = cmd_q;
        acc_d = acc_q;
        rdata_d = rdata_q;
        rsp_d = rsp_q;
        ack_d = ack_q;
        bp_d = bp_q;
        hi_d = hi_q;
        rout_d = rout_q;
        cfg_d = cfg_q;
        case (st_q)
            ST_IDLE: begin
                if (req_new) begin
                    cmd_d = cmd_hold;
                    st_d = ST_EXEC;
                end
            end
            ST_EXEC: begin
                st_d = ST_RESP;
                case (cmd_q.op)
                    OP_READ, OP_WRITE: begin
                        acc_d.req = 1'b1;
                        acc_d.write = (cmd_q.op == OP_WRITE);
                        acc_d.space = cmd_q.space;
                        acc_d.addr = cmd_q.addr;
                        acc_d.wdata = cmd_q.data;
                        st_d = ST_ACC;
                    end
                    OP_BP_ADDR: begin
                        for (int i = 0; i < NUM_BP; i++) begin
                            if (cmd_q.idx == 3'(i)) begin
                                bp_d[i].addr = cmd_q.addr;
                                bp_d[i].data = cmd_q.data;
                            end
                        end
                    end
                    OP_BP_QUAL: begin
                        for (int i = 0; i < NUM_BP; i++) begin
                            if (cmd_q.idx == 3'(i)) begin
                                bp_d[i].space_mask = cmd_q.addr[QB_SPACE_LSB +: 5];
                                bp_d[i].rd = cmd_q.addr[QB_RD];
                                bp_d[i].wr = cmd_q.addr[QB_WR];
                                bp_d[i].halt = cmd_q.addr[QB_HALT];
                                bp_d[i].evt = cmd_q.addr[QB_EVT];
                                bp_d[i].en = cmd_q.addr[QB_EN];
                                bp_d[i].dmatch = cmd_q.addr[QB_DMATCH];
                            end
                        end
                    end
                    OP_RANGE_HI: begin
                        hi_d = cmd_q.addr;
                        rout_d = cmd_q.data[0];
                    end
                    OP_CFG: cfg_d = cmd_q.data;
                    default: ;
                endcase
            end
            ST_ACC: begin
                if (dbg_gnt) begin
                    acc_d.req = 1'b0;
                    if (!acc_q.write) begin
                        rdata_d = dbg_rdata;
                    end
                    st_d = ST_RESP;
                end
            end
            ST_RESP: begin
                rsp_d.halted = halted_q;
                rsp_d.trace_vld = trace_vld_q;
                rsp_d.hit_mask = hit_q;
                rsp_d.rdata = rdata_q;
                rsp_d.trace_pc = trace_pc_q;
                ack_d = ~ack_q;
                st_d = ST_IDLE;
            end
            default: st_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            st_q <= ST_IDLE;
            cmd_q <= '0;
            acc_q <= '0;
            rdata_q <= 8'h00;
            rsp_q <= '0;
            ack_q <= 1'b0;
            for (int i = 0; i < NUM_BP; i++) begin
                bp_q[i] <= '0;
            end
            hi_q <= 16'h0000;
            rout_q <= 1'b0;
            cfg_q <= CFG_RST;
        end else begin
            st_q <= st_d;
            cmd_q <= cmd_d;
            acc_q <= acc_d;
            rdata_q <= rdata_d;
            rsp_q <= rsp_d;
            ack_q <= ack_d;
            bp_q <= bp_d;
            hi_q <= hi_d;
            rout_q <= rout_d;
            cfg_q <= cfg_d;
        end
    end

    // Run control, trace capture, hit status and event pulse.
    always_comb begin
        halted_d = halted_q;
        halt_pend_d = halt_pend_q;
        step_d = step_q;
        rst_d = (rst_q != 4'h0) ? rst_q - 4'h1 : rst_q;
        trace_vld_d = trace_vld_q;
        trace_pc_d = trace_pc_q;
        hit_d = hit_q;
        if (is_exec && cmd_q.op == OP_RUN) begin
            halted_d = 1'b0;
            halt_pend_d = 1'b0;
            step_d = 1'b0;
            hit_d = 6'h00;
        end
        if (is_exec && cmd_q.op == OP_HALT) begin
            halt_pend_d = 1'b1;
        end
        if (is_exec && cmd_q.op == OP_STEP && halted_q) begin
            halted_d = 1'b0;
            step_d = 1'b1;
        end
        if (is_exec && cmd_q.op == OP_RESET) begin
            rst_d = RST_CYCLES;
        end
        if (core_insn_boundary && !halted_q && (halt_pend_q || step_q)) begin
            halted_d = 1'b1;
            halt_pend_d = 1'b0;
            step_d = 1'b0;
        end
        halt_pend_d = halt_pend_d | brk_halt;
        hit_d = hit_d | {evt_fall, eff};
        if (st_q == ST_RESP) begin
            trace_vld_d = 1'b0;
        end
        if (trace_en && core_insn_boundary && !halted_q && !trace_vld_q) begin
            trace_vld_d = 1'b1;
            trace_pc_d = core_pc;
        end
        evto_d = !(brk_evt && evt_dir && evto_q);
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            halted_q <= 1'b0;
            halt_pend_q <= 1'b0;
            step_q <= 1'b0;
            rst_q <= 4'h0;
            trace_vld_q <= 1'b0;
            trace_pc_q <= 16'h0000;
            hit_q <= 6'h00;
            evto_q <= 1'b1;
        end else begin
            halted_q <= halted_d;
            halt_pend_q <= halt_pend_d;
            step_q <= step_d;
            rst_q <= rst_d;
            trace_vld_q <= trace_vld_d;
            trace_pc_q <= trace_pc_d;
            hit_q <= hit_d;
            evto_q <= evto_d;
        end
    end

    // Halt gates only the core; peripheral clocks are never stopped here.
    assign core_halt = halted_q;
    assign periph_clk_run = 1'b1;
    assign core_stall = trace_en && trace_vld_q;
    assign core_reset = (rst_q != 4'h0);
    assign dbg_acc = acc_q;
    assign evt_out = evto_q;
    assign evt_oe = evt_dir;

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    a_evt_one_cycle: assert property ($fell(evt_out) |=> evt_out)
        else $error("event pulse longer than one cycle");
    a_evt_idle_high: assert property (!evt_oe && !$past(evt_oe) |-> evt_out)
        else $error("event output low while not driving");
    a_brk_evt_low: assert property (brk_evt && evt_oe && evt_out |=> !evt_out)
        else $error("break did not pulse event output");
    a_halt_at_boundary: assert property ($rose(core_halt) |-> $past(core_insn_boundary))
        else $error("halt outside an instruction boundary");
    a_step_rehalt: assert property (step_q && core_insn_boundary && !core_halt |=> core_halt)
        else $error("single step did not re-halt");
    a_reset_len: assert property (is_exec && cmd_q.op == OP_RESET
        |=> core_reset [*4] ##1 !core_reset)
        else $error("core reset pulse length wrong");
    a_steal_hold: assert property (dbg_acc.req && !dbg_gnt
        |=> dbg_acc.req && $stable(dbg_acc.addr))
        else $error("debug access dropped before grant");
    a_steal_no_halt: assert property (dbg_acc.req && !core_halt && !halt_pend_q && !step_q
        && !brk_halt |=> !core_halt)
        else $error("debug access halted the core");
    a_trace_keep: assert property (core_stall && !(st_q == ST_RESP)
        |=> trace_vld_q && $stable(trace_pc_q))
        else $error("pending trace record lost");
    a_evt_in_brk: assert property (evt_fall |=> halt_pend_q || core_halt)
        else $error("event input edge did not break");

endmodule : odbu_core

// [odbu_core_tb_top.sv]
// Self-checking bench: debug unit against a breakpoint reference model.
`timescale 1ns/1ps
module odbu_core_tb_top import odbu_pkg::*; ();
    logic sys_clk, resetn, link_tck, link_frame, link_tdi, link_tdo, core_insn_boundary;
    logic core_halt, core_stall, core_reset, periph_clk_run, dbg_gnt, evt_in, evt_out;
    logic evt_oe, evt_ext, bnd_en, bnd_force, halt_p, rout;
    logic [15:0] core_pc, rhi;
    logic [7:0] dbg_rdata, g_rd;
    logic [1:0] comb, psel;
    logic [RSP_BITS-1:0] rsp;
    odbu_mon_s mon;
    odbu_acc_s dbg_acc, g_acc;
    logic [15:0] ba [NUM_BP];
    logic [7:0] bd [NUM_BP];
    logic [10:0] bq [NUM_BP];
    int error_cnt = 0, checks_done = 0, rst_run = 0, rst_len = 0, falls = 0;

    // The event pin is pulled up; the unit drives it only while its enable is high.
    assign evt_in = evt_oe ? evt_out : evt_ext;

    odbu_core i_dut (.sys_clk, .resetn, .link_tck, .link_frame, .link_tdi, .link_tdo,
        .core_pc, .core_insn_boundary, .mon, .core_halt, .core_stall, .core_reset,
        .periph_clk_run, .dbg_acc, .dbg_gnt, .dbg_rdata, .evt_in, .evt_out, .evt_oe);
    odbu_host_model i_host (.link_tck, .link_frame, .link_tdi, .link_tdo);

    // Core clock.
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    // Core side: random boundaries, late grants, reset length and halt release count.
    always @(posedge sys_clk) begin
        #1;
        core_insn_boundary = bnd_en ? 1'($urandom_range(0, 3) == 0) : bnd_force;
        dbg_rdata = 8'($urandom);
        dbg_gnt = dbg_acc.req && !dbg_gnt && ($urandom_range(0, 2) != 0);
        if (dbg_gnt) g_acc = dbg_acc;
        if (dbg_gnt) g_rd = dbg_rdata;
        if (halt_p && !core_halt) falls++;
        halt_p = core_halt;
        if (core_reset) rst_run++;
        else if (rst_run != 0) rst_len = rst_run;
        if (!core_reset) rst_run = 0;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic fin(input string n);
        $display("Test %0s ended, mismatches %0d", n, error_cnt);
    endtask : fin

    task automatic wrap_up();
        $display("Checks %0d, mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : wrap_up

    // One command frame; the frame gap leaves room for a slow steal.
    task automatic cmd(input odbu_op_e op, input logic [2:0] sp = 3'h0,
                       input logic [2:0] ix = 3'h0, input logic [15:0] a = 16'h0000,
                       input logic [7:0] d = 8'h00);
        i_host.xfer('{op, sp, ix, a, d}, rsp);
        repeat (20) @(posedge sys_clk);
        #1;
    endtask : cmd

    task automatic wait_halt(input logic v);
        for (int i = 0; i < 200 && core_halt !== v; i++) @(posedge sys_clk);
        #2 chk(core_halt, v);
    endtask : wait_halt

    task automatic bp(input int s, input logic [15:0] a, input logic [7:0] d,
                      input logic [10:0] q);
        ba[s] = a;
        bd[s] = d;
        bq[s] = q;
        cmd(OP_BP_ADDR, 3'h0, 3'(s), a, d);
        cmd(OP_BP_QUAL, 3'h0, 3'(s), {5'h00, q}, 8'h00);
    endtask : bp

    // Reference model: does this access raise a break with the event action.
    function automatic logic model_hit(input odbu_mon_s m);
        logic [NUM_BP-1:0] h;
        for (int s = 0; s < NUM_BP; s++) begin
            h[s] = bq[s][QB_EN] && bq[s][QB_EVT] && bq[s][QB_SPACE_LSB + int'(m.space)];
            h[s] &= bq[s][m.write ? QB_WR : QB_RD];
            if (s == BP_RANGE) h[s] &= ((m.addr >= ba[s] && m.addr <= rhi) != rout);
            else h[s] &= (m.addr == ba[s]) && (!bq[s][QB_DMATCH] || m.data == bd[s]);
        end
        if (comb == CB_AND) h[BP_DATA] &= h[psel];
        if (comb == CB_OR) h[BP_DATA] |= h[psel];
        if (comb == CB_AND || comb == CB_OR) h[psel] = 1'b0;
        return |h;
    endfunction : model_hit

    // One monitored access; on a modelled hit the event pin must pulse low for exactly one cycle.
    task automatic acc(input odbu_mon_s m);
        logic e;
        e = model_hit(m);
        @(posedge sys_clk);
        #1 mon = m;
        @(posedge sys_clk);
        #1 mon.valid = 1'b0;
        chk(evt_out, !e);
        @(posedge sys_clk);
        #1 chk(evt_out, 1'b1);
    endtask : acc

    // Main sequence.
    initial begin
        odbu_mon_s m;
        logic [15:0] a;
        logic [7:0] d;
        int b, f0;
        void'($urandom(49));
        {resetn, bnd_force, core_insn_boundary, dbg_gnt, rout} = 5'h00;
        {evt_ext, bnd_en} = 2'h3;
        {core_pc, rhi, dbg_rdata, comb, psel} = 44'h0;
        mon = '0;
        bq = '{default: '0};
        repeat (3) @(posedge sys_clk);
        #1 chk({core_halt, core_stall, core_reset, dbg_acc.req, evt_out, evt_oe,
                periph_clk_run}, 7'h05);
        @(posedge sys_clk);
        #1 resetn = 1'b1;
        for (int s = 0; s <= 5; s++) begin
            a = 16'($urandom);
            d = 8'($urandom);
            cmd(OP_WRITE, 3'(s), 3'h0, a, d);
            chk(g_acc, {2'b11, 3'(s), a, d});
            cmd(OP_READ, 3'(s), 3'h0, a);
            chk(g_acc[27:8], {1'b0, 3'(s), a});
            cmd(OP_NOP);
            chk(rsp[32:16], {3'b100, 6'h00, g_rd});
        end
        fin("steal");
        cmd(OP_RESET);
        chk(rst_len, 32'(RST_CYCLES));
        cmd(OP_HALT);
        wait_halt(1'b1);
        f0 = falls;
        cmd(OP_STEP);
        wait_halt(1'b1);
        chk(falls - f0, 1);
        cmd(OP_RUN);
        wait_halt(1'b0);
        fin("run control");
        for (int s = 0; s < NUM_BP; s++)
            bp(s, 16'($urandom_range(256, 320)), 8'($urandom), {1'(s == BP_DATA),
               3'b110, 2'($urandom_range(1, 3)), 5'($urandom) | 5'h15});
        for (int k = 0; k < 6; k++) begin
            comb = 2'(k % 3);
            psel = 2'($urandom_range(0, 2));
            rout = (k >= 3);
            rhi = ba[BP_RANGE] + 16'($urandom_range(0, 8));
            cmd(.op(OP_CFG), .d({2'b00, psel, comb, 2'b01}));
            chk(evt_oe, 1'b1);
            cmd(.op(OP_RANGE_HI), .ix(3'(BP_RANGE)), .a(rhi), .d({7'h00, rout}));
            repeat (24) begin
                b = $urandom_range(0, 5);
                m = '{1'b1, 1'($urandom), 3'($urandom_range(0, 4)),
                      (b == 5 ? rhi : ba[b]) + 16'($urandom_range(0, 2)) - 16'h0001,
                      bd[BP_DATA] ^ 8'($urandom_range(0, 1))};
                acc(m);
            end
        end
        fin("breakpoints");
        comb = 2'h0;
        cmd(.op(OP_CFG), .d(8'h01));
        cmd(OP_RUN);
        bnd_en = 1'b0;
        bp(0, 16'h2000, 8'h00, 11'h3FF);
        acc('{1'b1, 1'b0, 3'h0, 16'h2000, 8'h00});
        repeat (4) @(posedge sys_clk);
        #1 chk(core_halt, 1'b0);
        #1 bnd_force = 1'b1;
        @(posedge sys_clk);
        #2 bnd_force = 1'b0;
        chk(core_halt, 1'b0);
        @(posedge sys_clk);
        #2 chk(core_halt, 1'b1);
        cmd(OP_NOP);
        cmd(OP_NOP);
        chk({rsp[31], rsp[24], periph_clk_run}, 3'h7);
        bnd_en = 1'b1;
        cmd(OP_RUN);
        wait_halt(1'b0);
        fin("break halt");
        core_pc = 16'($urandom);
        cmd(.op(OP_CFG), .d(8'h02));
        chk(core_stall, 1'b1);
        repeat (3) begin
            a = core_pc;
            cmd(OP_NOP);
            core_pc = 16'($urandom);
            cmd(OP_NOP);
            chk({rsp[30], rsp[15:0]}, {1'b1, a});
        end
        cmd(.op(OP_CFG), .d(8'h00));
        cmd(OP_NOP);
        chk({core_stall, evt_oe}, 2'h0);
        fin("trace");
        evt_ext = 1'b0;
        wait_halt(1'b1);
        evt_ext = 1'b1;
        cmd(OP_NOP);
        cmd(OP_NOP);
        chk(rsp[29], 1'b1);
        fin("event input");
        wrap_up();
    end

    // Watchdog: the whole sequence needs well under half a millisecond.
    initial begin
        #500_000;
        error_cnt++;
        wrap_up();
    end
endmodule : odbu_core_tb_top

// [odbu_host_model.sv]
// Debug host probe model: shifts command frames in and answers out on the link.
`timescale 1ns/1ps
module odbu_host_model import odbu_pkg::*; (
    output logic link_tck,
    output logic link_frame,
    output logic link_tdi,
    input wire logic link_tdo
);
    // Two idle edges during reset, then the link clock stands still between frames.
    initial begin
        link_frame = 1'b0;
        link_tdi = 1'b1;
        link_tck = 1'b0;
        #2 link_tck = 1'b1;
        #16 link_tck = 1'b0;
    end

    // One frame sends a command LSB first and brings back the previous answer.
    task automatic xfer(input odbu_cmd_s cmd, output logic [RSP_BITS-1:0] rsp);
        logic [CMD_BITS-1:0] bits;
        bits = cmd;
        rsp = '0;
        link_frame = 1'b1;
        for (int i = 0; i < CMD_BITS; i++) begin
            link_tdi = bits[i];
            #16 link_tck = 1'b1;
            #8 if (i < RSP_BITS) rsp[i] = link_tdo;
            #8 link_tck = 1'b0;
        end
        #16 link_frame = 1'b0;
        link_tdi = ~link_tdi;
    endtask : xfer
endmodule : odbu_host_model

// [odbu_link.sv]
// Serial link end of the debug unit, clocked by the probe's link clock.
`timescale 1ns/1ps
module odbu_link import odbu_pkg::*; (
    input wire logic link_tck,
    input wire logic resetn,
    input wire logic link_frame,
    input wire logic link_tdi,
    output logic link_tdo,
    output odbu_cmd_s cmd_hold,
    output logic req_tgl,
    input wire logic ack_tgl,
    input wire odbu_rsp_s rsp_word
);

    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic [CMD_BITS-1:0] sr_q, sr_d;
    logic [RSP_BITS-1:0] out_q, out_d;
    odbu_cmd_s hold_q, hold_d;
    logic req_q, req_d;
    logic ack_s1_q, ack_s2_q;

    // Shift commands in, latch a full frame and flag it by a toggle; the
    // response word is stable whenever the acknowledge toggle matches.
    always_comb begin
        cnt_d = cnt_q;
        sr_d = sr_q;
        out_d = {1'b0, out_q[RSP_BITS-1:1]};
        hold_d = hold_q;
        req_d = req_q;
        if (!link_frame) begin
            cnt_d = '0;
            out_d = out_q;
        end else begin
            sr_d = {link_tdi, sr_q[CMD_BITS-1:1]};
            if (cnt_q == '0) begin
                out_d = {1'b0, rsp_word};
            end
            // The link clock stops between frames, so the acknowledge only passes both
            // stages during this frame; the fresh flag is filled in two edges later.
            if (cnt_q == CNT_W'(2)) begin
                out_d[RSP_BITS-3] = (ack_s2_q == req_q);
            end
            if (cnt_q == CNT_W'(CMD_BITS - 1)) begin
                cnt_d = '0;
                hold_d = odbu_cmd_s'({link_tdi, sr_q[CMD_BITS-1:1]});
                req_d = ~req_q;
            end else begin
                cnt_d = cnt_q + CNT_W'(1);
            end
        end
    end

    // Link-side registers and the acknowledge synchroniser.
    always_ff @(posedge link_tck or negedge resetn) begin
        if (!resetn) begin
            cnt_q <= '0;
            sr_q <= '0;
            out_q <= '0;
            hold_q <= '0;
            req_q <= 1'b0;
            ack_s1_q <= 1'b0;
            ack_s2_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            sr_q <= sr_d;
            out_q <= out_d;
            hold_q <= hold_d;
            req_q <= req_d;
            ack_s1_q <= ack_tgl;
            ack_s2_q <= ack_s1_q;
        end
    end

    assign link_tdo = out_q[0];
    assign cmd_hold = hold_q;
    assign req_tgl = req_q;

endmodule : odbu_link

// [odbu_pkg.sv]
// Shared constants, command and response layouts for the on-chip debug unit.
package odbu_pkg;

    // Link frame and response sizes.
    localparam int CMD_BITS = 34;
    localparam int RSP_BITS = 33;
    localparam int CNT_W = 6;

    // Breakpoint slots: three address matches, one data match, one range.
    localparam int NUM_BP = 5;
    localparam int NUM_MATCH = 3;
    localparam int BP_DATA = 3;
    localparam int BP_RANGE = 4;

    // Core reset pulse length in sys_clk cycles.
    localparam logic [3:0] RST_CYCLES = 4'h4;

    // Qualifier field positions inside the address field of a qualifier command.
    localparam int QB_SPACE_LSB = 0;
    localparam int QB_RD = 5;
    localparam int QB_WR = 6;
    localparam int QB_HALT = 7;
    localparam int QB_EVT = 8;
    localparam int QB_EN = 9;
    localparam int QB_DMATCH = 10;

    // Configuration byte field positions.
    localparam int CF_EVT_OUT = 0;
    localparam int CF_TRACE = 1;
    localparam int CF_COMB_LSB = 2;
    localparam int CF_SEL_LSB = 4;
    localparam logic [7:0] CFG_RST = 8'h00;

    // Combination modes of the data breakpoint with a partner slot.
    localparam logic [1:0] CB_AND = 2'h1;
    localparam logic [1:0] CB_OR = 2'h2;

    // Host commands.
    typedef enum logic [3:0] {
        OP_NOP = 4'h0,
        OP_HALT = 4'h1,
        OP_RUN = 4'h2,
        OP_STEP = 4'h3,
        OP_RESET = 4'h4,
        OP_READ = 4'h5,
        OP_WRITE = 4'h6,
        OP_BP_ADDR = 4'h7,
        OP_BP_QUAL = 4'h8,
        OP_RANGE_HI = 4'h9,
        OP_CFG = 4'hA
    } odbu_op_e;

    // Memory spaces; the first five can qualify a breakpoint.
    typedef enum logic [2:0] {
        SP_CODE = 3'h0,
        SP_SFR = 3'h1,
        SP_DATA = 3'h2,
        SP_IDATA = 3'h3,
        SP_XDATA = 3'h4,
        SP_CREG = 3'h5
    } odbu_space_e;

    // Command handling states, Gray coded along the read/write path.
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_EXEC = 2'h1,
        ST_ACC = 2'h3,
        ST_RESP = 2'h2
    } odbu_state_e;

    typedef struct packed {
        odbu_op_e op;
        logic [2:0] space;
        logic [2:0] idx;
        logic [15:0] addr;
        logic [7:0] data;
    } odbu_cmd_s;

    typedef struct packed {
        logic halted;
        logic trace_vld;
        logic [5:0] hit_mask;
        logic [7:0] rdata;
        logic [15:0] trace_pc;
    } odbu_rsp_s;

    typedef struct packed {
        logic valid;
        logic write;
        logic [2:0] space;
        logic [15:0] addr;
        logic [7:0] data;
    } odbu_mon_s;

    typedef struct packed {
        logic req;
        logic write;
        logic [2:0] space;
        logic [15:0] addr;
        logic [7:0] wdata;
    } odbu_acc_s;

    typedef struct packed {
        logic en;
        logic rd;
        logic wr;
        logic halt;
        logic evt;
        logic dmatch;
        logic [4:0] space_mask;
        logic [15:0] addr;
        logic [7:0] data;
    } odbu_bp_s;

endpackage : odbu_pkg
